// file: include/mei_regs.vh
// Register map and timing constants of the motion event register block.
// Assumes inclusion by the block's single design file only.
`ifndef MEI_REGS_VH
`define MEI_REGS_VH
`define MEI_ADDR_PREV_ORIENT 8'h11
`define MEI_ADDR_TAP_SRC 8'h15
`define MEI_ADDR_FUNC_SRC 8'h16
`define MEI_ADDR_STATUS 8'h18
`define MEI_ADDR_RELEASE 8'h1a
`define MEI_ADDR_MAIN_CTRL 8'h1b
`define MEI_ADDR_ORIENT_EN 8'h1c
`define MEI_ADDR_PIN_CTRL 8'h1e
`define MEI_RST_PREV_ORIENT 6'h20
`define MEI_RST_MAIN_CTRL 8'h00
`define MEI_RST_ORIENT_EN 8'h3f
`define MEI_RST_PIN_CTRL 2'h0
`define MEI_BIT_RUN 7
`define MEI_BIT_PRECISION 6
`define MEI_BIT_NEWSAMP_EN 5
`define MEI_BIT_RANGE_HI 4
`define MEI_BIT_RANGE_LO 3
`define MEI_BIT_TAP_EN 2
`define MEI_BIT_MOTION_EN 1
`define MEI_BIT_ORIENT_EN 0
`define MEI_BIT_TAP_RATE 7
`define MEI_BIT_PIN_PULSE 3
`define MEI_BIT_PIN_UNLATCH 2
`define MEI_MASK_ORIENT_EN 8'hbf
`define MEI_PULSE_NS 40000
`define MEI_CLK_NS 25
`endif

// file: logic/mei_event_regs.v
// Event reporting and main control registers of a motion sensor.
// Assumes a register port (addr, write and read strobes) on ref_clk and
// one-cycle event strobes from detection logic on the same clock.
`include "mei_regs.vh"

module mei_event_regs #(
    parameter PULSE_CYC = (`MEI_PULSE_NS + `MEI_CLK_NS - 1) / `MEI_CLK_NS
)(
    input wire ref_clk,
    input wire rst_b,
    input wire [7:0] regAddr,
    input wire regWr,
    input wire regRd,
    input wire [7:0] regWdata,
    output reg [7:0] regRdata,
    input wire orientUpdate,
    input wire [5:0] orientCur,
    input wire tapEvent,
    input wire tapDouble,
    input wire [5:0] tapDir,
    input wire motionEvent,
    input wire motionLevel,
    input wire newSample,
    input wire sampleRead,
    input wire bufThreshold,
    input wire bufTriggerMode,
    output reg irqPin,
    output reg runSelect,
    output reg precisionSelect,
    output reg [1:0] rangeSel,
    output reg tapFnEn,
    output reg motionFnEn,
    output reg orientFnEn,
    output reg tapRateRange
);

    // Pulse counter width; a pulse longer than its range keeps only its low 12 bits and wraps
    // Default pulse lands mid-band of the allowed pulse length
    localparam CNT_W = 12;
    localparam [CNT_W-1:0] PULSE_LOAD = PULSE_CYC[CNT_W-1:0];
    localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};

    // Pin machine states, one-hot
    localparam [3:0] PIN_IDLE = 4'h1;
    localparam [3:0] PIN_LATCH = 4'h2;
    localparam [3:0] PIN_PULSE = 4'h4;
    localparam [3:0] PIN_FOLLOW = 4'h8;

    reg [5:0] prevOrient_reg;
    reg [5:0] lastOrient_reg;
    reg [5:0] tapSrc_reg;
    reg bufThreshFlag_reg;
    reg newSampleFlag_reg;
    reg [1:0] tapType_reg;
    reg motionFlag_reg;
    reg orientChgFlag_reg;
    reg intStatus_reg;
    reg [7:0] mainCtrl_reg;
    reg [7:0] orientEn_reg;
    reg [1:0] pinCtrl_reg;
    reg [CNT_W-1:0] pulseCnt_reg;
    reg readHold_reg;
    // Pin machine
    reg [3:0] pinState_reg;
    // Next-state values of the pin machine
    reg [3:0] pinState_next;
    reg irqPin_next;
    reg [CNT_W-1:0] pulseCnt_next;

    wire relRead;
    wire orientHit;
    wire unlatchedMotion;
    wire anyEvent;
    wire motionOnly;
    wire tapOn;
    wire motionOn;
    wire orientOn;
    wire newSampIrqOn;

    // Address match shared by the strobes and the write decode
    // Kept as a function so the strobes and the write decode compare the same way
    function addrIs;
        input [7:0] addr;
        input [7:0] target;
        begin
            addrIs = (addr == target);
        end
    endfunction

    // Release read strobe shared by every latched flag
    assign relRead = regRd && addrIs(regAddr, `MEI_ADDR_RELEASE);
    // Enable bits by name so the event terms read plainly
    assign tapOn = mainCtrl_reg[`MEI_BIT_TAP_EN];
    assign motionOn = mainCtrl_reg[`MEI_BIT_MOTION_EN];
    assign orientOn = mainCtrl_reg[`MEI_BIT_ORIENT_EN];
    assign newSampIrqOn = mainCtrl_reg[`MEI_BIT_NEWSAMP_EN];
    // Only states whose enable bit is set raise the change flag
    assign orientHit = orientUpdate && !readHold_reg && orientOn &&
        (orientCur != lastOrient_reg) &&
        |(orientCur & orientEn_reg[5:0]);
    // Follow mode needs motion enabled with tap, orientation and new-sample enables clear
    assign motionOnly = motionOn && !tapOn && !orientOn && !newSampIrqOn;
    assign unlatchedMotion = pinCtrl_reg[0] && motionOnly;
    assign anyEvent = orientHit ||
        (tapEvent && tapOn) ||
        (motionEvent && motionOn && !unlatchedMotion) ||
        (newSample && newSampIrqOn) ||
        (bufThreshold && !bufTriggerMode);

    // Reads of the orientation register freeze updates for one cycle
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            readHold_reg <= 1'b0;
            prevOrient_reg <= `MEI_RST_PREV_ORIENT;
            lastOrient_reg <= `MEI_RST_PREV_ORIENT;
        end
        else
        begin
            readHold_reg <= regRd && addrIs(regAddr, `MEI_ADDR_PREV_ORIENT);
            if (orientUpdate && !readHold_reg &&
                orientCur != lastOrient_reg)
            begin
                prevOrient_reg <= lastOrient_reg;
                lastOrient_reg <= orientCur;
            end
        end
    end

    // Latched sources: a new event wins over a release in the same cycle
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tapSrc_reg <= 6'h00;
            tapType_reg <= 2'h0;
            bufThreshFlag_reg <= 1'b0;
            newSampleFlag_reg <= 1'b0;
            motionFlag_reg <= 1'b0;
            orientChgFlag_reg <= 1'b0;
            intStatus_reg <= 1'b0;
        end
        else
        begin
            if (tapEvent && tapOn)
            begin
                tapSrc_reg <= tapDir;
                tapType_reg <= tapDouble ? 2'h2 : 2'h1;
            end
            else if (relRead)
            begin
                tapSrc_reg <= 6'h00;
                tapType_reg <= 2'h0;
            end
            if (bufThreshold && !bufTriggerMode)
                bufThreshFlag_reg <= 1'b1;
            else if (relRead)
                bufThreshFlag_reg <= 1'b0;
            if (newSample)
                newSampleFlag_reg <= 1'b1;
            else if (relRead || sampleRead)
                newSampleFlag_reg <= 1'b0;
            if (unlatchedMotion)
                motionFlag_reg <= motionLevel;
            else if (motionEvent && motionOn)
                motionFlag_reg <= 1'b1;
            else if (relRead || sampleRead)
                motionFlag_reg <= 1'b0;
            if (orientHit)
                orientChgFlag_reg <= 1'b1;
            else if (relRead)
                orientChgFlag_reg <= 1'b0;
            if (anyEvent)
                intStatus_reg <= 1'b1;
            else if (relRead)
                intStatus_reg <= 1'b0;
        end
    end

    // Configuration writes; standby ordering is left to the host
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mainCtrl_reg <= `MEI_RST_MAIN_CTRL;
            orientEn_reg <= `MEI_RST_ORIENT_EN;
            pinCtrl_reg <= `MEI_RST_PIN_CTRL;
        end
        else if (regWr)
        begin
            if (addrIs(regAddr, `MEI_ADDR_MAIN_CTRL))
                mainCtrl_reg <= regWdata;
            else if (addrIs(regAddr, `MEI_ADDR_ORIENT_EN))
                orientEn_reg <= regWdata & `MEI_MASK_ORIENT_EN;
            // Pin control keeps only pulse and follow selects
            else if (addrIs(regAddr, `MEI_ADDR_PIN_CTRL))
                pinCtrl_reg <= {regWdata[`MEI_BIT_PIN_PULSE],
                    regWdata[`MEI_BIT_PIN_UNLATCH]};
        end
    end

    // Pin next state: latched, one short pulse, or following motion
    always @*
    begin
        pinState_next = pinState_reg;
        irqPin_next = irqPin;
        pulseCnt_next = pulseCnt_reg;
        if (unlatchedMotion)
        begin
            // Follow mode ignores the release read entirely
            pinState_next = PIN_FOLLOW;
            irqPin_next = motionLevel;
            pulseCnt_next = CNT_ZERO;
        end
        else
        begin
            case (pinState_reg)
                PIN_IDLE:
                begin
                    // Pulse select decides how a fresh event drives the pin
                    if (anyEvent && pinCtrl_reg[1])
                    begin
                        pinState_next = PIN_PULSE;
                        irqPin_next = 1'b1;
                        pulseCnt_next = PULSE_LOAD;
                    end
                    else if (anyEvent)
                    begin
                        pinState_next = PIN_LATCH;
                        irqPin_next = 1'b1;
                    end
                    else
                        irqPin_next = 1'b0;
                end
                PIN_LATCH:
                begin
                    // A new event in the release cycle keeps the pin up while pulse select is clear
                    if ((relRead && !anyEvent) || pinCtrl_reg[1])
                    begin
                        pinState_next = PIN_IDLE;
                        irqPin_next = 1'b0;
                    end
                    else
                        irqPin_next = 1'b1;
                end
                PIN_PULSE:
                begin
                    // Events during a pulse are not queued
                    if (pulseCnt_reg > CNT_ONE)
                        pulseCnt_next = pulseCnt_reg - CNT_ONE;
                    else
                    begin
                        pinState_next = PIN_IDLE;
                        irqPin_next = 1'b0;
                        pulseCnt_next = CNT_ZERO;
                    end
                end
                PIN_FOLLOW:
                begin
                    // Leaving follow mode starts again from a low pin
                    pinState_next = PIN_IDLE;
                    irqPin_next = 1'b0;
                end
                default:
                begin
                    pinState_next = PIN_IDLE;
                    irqPin_next = 1'b0;
                    pulseCnt_next = CNT_ZERO;
                end
            endcase
        end
    end

    // Pin register: the pin itself leaves straight from a flip-flop
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pinState_reg <= PIN_IDLE;
            irqPin <= 1'b0;
            pulseCnt_reg <= CNT_ZERO;
        end
        else
        begin
            pinState_reg <= pinState_next;
            irqPin <= irqPin_next;
            pulseCnt_reg <= pulseCnt_next;
        end
    end

    // Control outputs mirror the control registers
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            runSelect <= 1'b0;
            precisionSelect <= 1'b0;
            rangeSel <= 2'h0;
            tapFnEn <= 1'b0;
            motionFnEn <= 1'b0;
            orientFnEn <= 1'b0;
            tapRateRange <= 1'b0;
        end
        else
        begin
            runSelect <= mainCtrl_reg[`MEI_BIT_RUN];
            precisionSelect <= mainCtrl_reg[`MEI_BIT_PRECISION];
            rangeSel <= {mainCtrl_reg[`MEI_BIT_RANGE_HI],
                mainCtrl_reg[`MEI_BIT_RANGE_LO]};
            tapFnEn <= mainCtrl_reg[`MEI_BIT_TAP_EN];
            motionFnEn <= mainCtrl_reg[`MEI_BIT_MOTION_EN];
            orientFnEn <= mainCtrl_reg[`MEI_BIT_ORIENT_EN];
            tapRateRange <= orientEn_reg[`MEI_BIT_TAP_RATE];
        end
    end

    // Read data registered; unmapped and release reads return zero
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            regRdata <= 8'h00;
        else if (regRd)
        begin
            if (regAddr == `MEI_ADDR_PREV_ORIENT)
                regRdata <= {2'h0, prevOrient_reg};
            else if (regAddr == `MEI_ADDR_TAP_SRC)
                regRdata <= {2'h0, tapSrc_reg};
            else if (regAddr == `MEI_ADDR_FUNC_SRC)
                regRdata <= {2'h0, bufThreshFlag_reg, newSampleFlag_reg,
                    tapType_reg, motionFlag_reg, orientChgFlag_reg};
            else if (regAddr == `MEI_ADDR_STATUS)
                regRdata <= {3'h0, intStatus_reg, 4'h0};
            else if (regAddr == `MEI_ADDR_MAIN_CTRL)
                regRdata <= mainCtrl_reg;
            else if (regAddr == `MEI_ADDR_ORIENT_EN)
                // Reserved bit 6 is masked at write time
                regRdata <= orientEn_reg;
            else if (regAddr == `MEI_ADDR_PIN_CTRL)
                regRdata <= {4'h0, pinCtrl_reg, 2'h0};
            else
                regRdata <= 8'h00;
        end
    end

endmodule // mei_event_regs

// file: sim/mei_event_regs_asserts.sv
// Port assertions for the motion event register block.
// Bound into every mei_event_regs; sees only that module's ports.
module mei_event_regs_asserts(
    input wire ref_clk,
    input wire rst_b,
    input wire [7:0] regAddr,
    input wire regWr,
    input wire regRd,
    input wire [7:0] regWdata,
    input wire [7:0] regRdata,
    input wire runSelect,
    input wire precisionSelect,
    input wire [1:0] rangeSel,
    input wire tapFnEn,
    input wire motionFnEn,
    input wire orientFnEn,
    input wire tapRateRange
);
    timeunit 1ns;
    timeprecision 100ps;
    // One domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_release_zero:
        assert property (regRd && regAddr == 8'h1a |=> regRdata == 8'h00)
        else $error("release read data not zero");
    a_prev_top_zero:
        assert property (regRd && regAddr == 8'h11 |=> regRdata[7:6] == 0)
        else $error("orientation top bits set");
    a_tap_top_zero:
        assert property (regRd && regAddr == 8'h15 |=> regRdata[7:6] == 0)
        else $error("tap source top bits set");
    a_tap_type_ok:
        assert property (regRd && regAddr == 8'h16 |=>
            regRdata[3:2] != 2'h3 && regRdata[7:6] == 2'h0)
        else $error("bad tap type or top bits");
    a_status_bits:
        assert property (regRd && regAddr == 8'h18 |=>
            (regRdata & 8'hef) == 8'h00)
        else $error("status bits other than bit 4");
    a_ctrl_mirror:
        assert property (regWr && regAddr == 8'h1b ##2 1 |->
            {runSelect, precisionSelect, rangeSel, tapFnEn, motionFnEn,
            orientFnEn} == {$past(regWdata[7:6], 2), $past(regWdata[4:0], 2)})
        else $error("control outputs differ from written byte");
    a_rate_mirror:
        assert property (regWr && regAddr == 8'h1c ##2 1 |->
            tapRateRange == $past(regWdata[7], 2))
        else $error("tap rate range differs from written bit");
    a_rdata_holds:
        assert property (!regRd |=> $stable(regRdata))
        else $error("read data changed without a read");
endmodule // mei_event_regs_asserts

bind mei_event_regs mei_event_regs_asserts u_chk(.ref_clk, .rst_b,
    .regAddr, .regWr, .regRd, .regWdata, .regRdata, .runSelect,
    .precisionSelect, .rangeSel, .tapFnEn, .motionFnEn, .orientFnEn,
    .tapRateRange);

// file: sim/mei_host_model.sv
// Host side of the register port: one-cycle write and read strobes.
// Assumes read data is valid the cycle after the read strobe.
module mei_host_model(
    input wire ref_clk,
    input wire [7:0] regRdata,
    output logic [7:0] regAddr,
    output logic regWr,
    output logic regRd,
    output logic [7:0] regWdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {regAddr, regWr, regRd, regWdata} = 18'h0;
    // Data is inverted after a write so a stale byte never looks valid
    task automatic wr(input [7:0] a, input [7:0] d);
        @(posedge ref_clk);
        #2 regAddr = a;
        regWdata = d;
        regWr = 1'b1;
        @(posedge ref_clk);
        #2 regWr = 1'b0;
        regWdata = ~d;
    endtask
    // Read byte taken just after the edge that answers the strobe
    task automatic rd(input [7:0] a, output [7:0] d);
        @(posedge ref_clk);
        #2 regAddr = a;
        regRd = 1'b1;
        @(posedge ref_clk);
        #2 regRd = 1'b0;
        d = regRdata;
    endtask
endmodule // mei_host_model

// file: sim/tb_mei_event_regs.sv
// Self-checking bench for the motion event register block.
// Host model drives the register port; event strobes come from here.
module tb_mei_event_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 0;
    logic rst_b = 0;
    logic [7:0] regAddr, regWdata, regRdata, d;
    logic regWr, regRd, irqPin, runSelect, precisionSelect;
    logic tapFnEn, motionFnEn, orientFnEn, tapRateRange;
    logic [1:0] rangeSel;
    logic [5:0] orientCur = 6'h20;
    logic [5:0] tapDir = 6'h00;
    logic [5:0] ev = 6'h00; // Orient, tap, motion, sample, read, thresh
    logic tapDouble = 0, motionLevel = 0, bufTriggerMode = 0;
    int error_cnt = 0, checked = 0, tn = 0, hi = 0, i;
    initial forever #12.5 ref_clk = ~ref_clk;
    mei_event_regs dut(.ref_clk, .rst_b, .regAddr, .regWr, .regRd,
        .regWdata, .regRdata, .orientUpdate(ev[5]), .orientCur,
        .tapEvent(ev[4]), .tapDouble, .tapDir, .motionEvent(ev[3]),
        .motionLevel, .newSample(ev[2]), .sampleRead(ev[1]),
        .bufThreshold(ev[0]), .bufTriggerMode, .irqPin, .runSelect,
        .precisionSelect, .rangeSel, .tapFnEn, .motionFnEn, .orientFnEn,
        .tapRateRange);
    mei_host_model h(.ref_clk, .regRdata, .regAddr, .regWr, .regRd,
        .regWdata);
    // Pin high cycles, sampled before the edge's own updates
    always @(posedge ref_clk) if (irqPin === 1'b1) hi++;
    task automatic chk(input [7:0] s, input [7:0] e);
        checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, s, e);
        end
    endtask
    task automatic rc(input [7:0] a, input [7:0] e);
        h.rd(a, d);
        chk(d, e);
    endtask
    task automatic pulse(input [5:0] m);
        @(posedge ref_clk);
        #2 ev = m;
        @(posedge ref_clk);
        #2 ev = 6'h00;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task endt;
        $display("test %0d done", ++tn);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        cyc(6);
        rst_b = 1;
        // Reset values, read-only and unmapped places
        rc(8'h11, 8'h20);
        rc(8'h1b, 8'h00);
        rc(8'h1c, 8'h3f);
        h.wr(8'h11, 8'hff);
        rc(8'h11, 8'h20);
        rc(8'h30, 8'h00);
        h.wr(8'h1c, 8'hff);
        rc(8'h1c, 8'hbf);
        chk({7'h0, tapRateRange}, 8'h01);
        endt();
        // Range codes 0 to 2, written in standby
        for (i = 0; i < 3; i++)
        begin
            h.wr(8'h1b, {3'h2, i[1:0], 3'h7});
            rc(8'h1b, {3'h2, i[1:0], 3'h7});
            chk({5'h0, precisionSelect, rangeSel}, {6'h01, i[1:0]});
        end
        h.wr(8'h1b, 8'h37);
        h.wr(8'h1b, 8'hb7);
        cyc(2);
        chk({runSelect, precisionSelect, tapFnEn, motionFnEn, orientFnEn},
            8'h17);
        endt();
        // Double then single tap, latched until release
        tapDir = 6'h24;
        tapDouble = 1;
        pulse(6'h10);
        rc(8'h15, 8'h24);
        rc(8'h16, 8'h08);
        rc(8'h18, 8'h10);
        chk({7'h0, irqPin}, 8'h01);
        rc(8'h1a, 8'h00);
        rc(8'h15, 8'h00);
        rc(8'h16, 8'h00);
        rc(8'h18, 8'h00);
        chk({7'h0, irqPin}, 8'h00);
        tapDouble = 0;
        pulse(6'h10);
        rc(8'h16, 8'h04);
        rc(8'h1a, 8'h00);
        endt();
        // Motion, new sample and threshold; data read clears two
        pulse(6'h0d);
        rc(8'h16, 8'h32);
        pulse(6'h02);
        rc(8'h16, 8'h20);
        rc(8'h1a, 8'h00);
        bufTriggerMode = 1;
        pulse(6'h01);
        rc(8'h16, 8'h00);
        bufTriggerMode = 0;
        pulse(6'h04);
        rc(8'h18, 8'h10);
        rc(8'h1a, 8'h00);
        endt();
        // Orientation history, then masked states and disabled tap
        orientCur = 6'h01;
        pulse(6'h20);
        rc(8'h16, 8'h01);
        orientCur = 6'h04;
        pulse(6'h20);
        rc(8'h11, 8'h01);
        rc(8'h1a, 8'h00);
        h.wr(8'h1b, 8'h33);
        h.wr(8'h1c, 8'h80);
        h.wr(8'h1b, 8'hb3);
        orientCur = 6'h02;
        pulse(6'h30);
        rc(8'h16, 8'h00);
        endt();
        // Pin pulse mode, motion only
        h.wr(8'h1b, 8'h02);
        h.wr(8'h1e, 8'h08);
        h.wr(8'h1b, 8'h82);
        pulse(6'h04);
        rc(8'h18, 8'h00);
        rc(8'h16, 8'h10);
        rc(8'h1a, 8'h00);
        hi = 0;
        pulse(6'h08);
        cyc(2500);
        chk({7'h0, hi >= 1200 && hi <= 2000}, 8'h01);
        chk({7'h0, irqPin}, 8'h00);
        rc(8'h1a, 8'h00);
        // Unlatched mode: pin and flag follow the motion level
        h.wr(8'h1b, 8'h02);
        h.wr(8'h1e, 8'h04);
        h.wr(8'h1b, 8'h82);
        motionLevel = 1;
        cyc(2);
        chk({7'h0, irqPin}, 8'h01);
        rc(8'h16, 8'h02);
        motionLevel = 0;
        cyc(2);
        chk({7'h0, irqPin}, 8'h00);
        rc(8'h16, 8'h00);
        endt();
        wrap_up();
    end
endmodule // tb_mei_event_regs
